// ### bde_params.svh
// Constants for the background debug entry block.
// Assumes inclusion by bare name; definitions only.
`ifndef BDE_PARAMS_SVH
`define BDE_PARAMS_SVH

// ----------------------------------------------------------------
// Opcodes seen on the instruction decode port
// ----------------------------------------------------------------
`define BDE_OPC_DEBUG      16'h4AFA
`define BDE_OPC_SWBKPT_LO  16'h4848
`define BDE_OPC_SWBKPT_HI  16'h484F

// ----------------------------------------------------------------
// Exception and entry-source values
// ----------------------------------------------------------------
`define BDE_VEC_BREAKPOINT_REQUEST_N       8'h0C
`define BDE_SRC_DBL_LO     16'hFFFF
`define BDE_SRC_OPC_LO     16'h0001
`define BDE_SRC_ZERO       16'h0000
`define BDE_CIP_DBL_RESET  32'h0FFFFFFF

// ----------------------------------------------------------------
// Serial word layout and response encodings
// ----------------------------------------------------------------
`define BDE_FRAME_BITS     17
`define BDE_LAST_BIT       5'h10
`define BDE_RSP_NOT_READY  17'h10000
`define BDE_RSP_BUS_ERROR  17'h10001
`define BDE_RSP_ILLEGAL    17'h1FFFF
`define BDE_RSP_COMPLETE   17'h0FFFF

// ----------------------------------------------------------------
// Serial command operation words
// ----------------------------------------------------------------
`define BDE_CMD_READ_SYSTEM_REG_CMD_HI   16'h2D80
`define BDE_CMD_READ_SYSTEM_REG_CMD_LO   16'h2D81
`define BDE_CMD_WSREG      16'h2480
`define BDE_CMD_GO         16'h0C00
`define BDE_CMD_CALL       16'h0800

`endif

// ### bde_pkg.sv
// Types shared by the background debug entry block.
// Assumes nothing beyond a SystemVerilog compiler.
package bde_pkg;

  // Core events sampled each clock, all same-clock pulses
  typedef struct packed {
    logic breakpoint_request_n_ack;
    logic breakpoint_request_n_prefetch;
    logic prefetch_flushed;
    logic periph_breakpoint_request_n;
    logic bus_fault;
    logic fault_done;
    logic reset_fetch;
    logic opcode_valid;
    logic pipe_load;
    logic pipe_flush;
    logic pipe_advance;
    logic instr_start;
  } bde_event_type;

  // Core sequencer states
  typedef enum logic [1:0] {
    ST_RUN,
    ST_WAIT,
    ST_EXT,
    ST_EXIT
  } bde_state_type;

endpackage : bde_pkg

// ### bde_sync.sv
// Two-flop level synchroniser into the clk domain.
// Assumes d is a level or toggle from another clock domain.
`timescale 1ns/1ps
`default_nettype none

module bde_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    stage1_reg <= d;
    stage2_reg <= stage1_reg;
  end

  assign q = stage2_reg;

endmodule : bde_sync

`default_nettype wire

// ### bde_link.sv
// Serial receive logic clocked by the debug serial clock.
// Assumes link_clear comes from a core flop; held while not halted.
`timescale 1ns/1ps
`default_nettype none
`include "bde_params.svh"

module bde_link (
  input  wire logic        debug_serial_clock,
  input  wire logic        link_clear,
  input  wire logic        serial_in,
  output var  logic        bit_toggle,
  output var  logic [16:0] rx_word
);

  logic [15:0] shift_reg;
  logic [15:0] shift_next;
  logic [4:0]  count_reg;
  logic [4:0]  count_next;
  logic        toggle_reg;
  logic        toggle_next;
  logic [16:0] hold_reg;
  logic [16:0] hold_next;

  // Shift MSB first, flag each bit, latch the 17th
  always_comb begin
    shift_next  = {shift_reg[14:0], serial_in};
    toggle_next = ~toggle_reg;
    hold_next   = hold_reg;
    count_next  = count_reg + 5'h01;
    if (count_reg == `BDE_LAST_BIT) begin
      hold_next  = {shift_reg, serial_in};
      count_next = 5'h00;
    end
  end

  // Cleared whenever the serial subsystem is off
  always_ff @(posedge debug_serial_clock or posedge link_clear) begin
    if (link_clear) begin
      shift_reg  <= 16'h0000;
      count_reg  <= 5'h00;
      toggle_reg <= 1'b0;
      hold_reg   <= 17'h00000;
    end else begin
      shift_reg  <= shift_next;
      count_reg  <= count_next;
      toggle_reg <= toggle_next;
      hold_reg   <= hold_next;
    end
  end

  assign bit_toggle = toggle_reg;
  assign rx_word    = hold_reg;

endmodule : bde_link

`default_nettype wire

// ### bde_top.sv
// Background debug entry and serial command control.
// Assumes core events on clk; serial clock from the debug host.
// Summary of operation
// - Enable latched from low breakpoint at reset release
// - Enable held until next reset, which clears it
// - Enabled: breakpoint, opcode, double fault enter debug
// - Disabled: breakpoint gives exception vector 0C
// - Double fault halts, or enters debug if enabled
// - Debug opcode enters, or illegal trap if disabled
// - Software breakpoint opcode never enters debug
// - No acknowledge cycle when entering debug
// - Entry suspends execution, raises halted, awaits command
// - Entry source written to temporary register
// - Odd pointer only for double fault at reset
// - Command is operation word plus extension words
// - Take each word; WSREG writes each half as its word arrives
// - Result shifts out during next command
// - In debug, fetching stops; serial only
// - Fetch and pipe tracking outputs driven
// - Flushed prefetch breakpoints ignored, operand kept
// - Serial word is 17 bits, MSB first
// - Status responses not ready, illegal, complete; bus error never sent
// - Halted drops before first resumed prefetch
`timescale 1ns/1ps
`default_nettype none
`include "bde_params.svh"

module bde_top (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  breakpoint_request_n,
  input  wire logic                  debug_serial_clock,
  input  wire bde_pkg::bde_event_type core_event,
  input  wire logic [15:0]           opcode,
  input  wire logic [15:0]           fault_status_word,
  input  wire logic                  fetch_track_in,
  output var  logic                  fetch_track_out,
  output var  logic                  fetch_track_oe,
  output var  logic                  pipe_track_out_hi,
  output var  logic                  pipe_track_out_lo,
  output var  logic                  halted_out,
  output var  logic                  fetch_stop,
  output var  logic                  resume_prefetch,
  output var  logic                  debug_enabled,
  output var  logic                  breakpoint_request_n_exception,
  output var  logic [7:0]            exception_vector,
  output var  logic                  breakpoint_request_n_ack_cycle,
  output var  logic                  illegal_trap,
  output var  logic                  system_halt,
  output var  logic [31:0]           entry_source_temp,
  output var  logic                  cip_write,
  output var  logic [31:0]           cip_value
);

  // ----------------------------------------------------------------
  // Synchronisers and link-domain receiver
  // ----------------------------------------------------------------
  logic        breakpoint_request_n_n_sync;
  logic        toggle_sync;
  logic        link_toggle;
  logic [16:0] rx_word;
  logic        serial_off_reg;
  logic        serial_off_next;

  bde_sync #(.WIDTH(1)) u_breakpoint_request_n_sync (
    .clk (clk),
    .d   (breakpoint_request_n),
    .q   (breakpoint_request_n_n_sync)
  );

  bde_sync #(.WIDTH(1)) u_toggle_sync (
    .clk (clk),
    .d   (link_toggle),
    .q   (toggle_sync)
  );

  bde_link u_link (
    .debug_serial_clock (debug_serial_clock),
    .link_clear         (serial_off_reg),
    .serial_in          (fetch_track_in),
    .bit_toggle         (link_toggle),
    .rx_word            (rx_word)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  bde_pkg::bde_state_type state_reg, state_next;
  logic        rst_d_reg;
  logic        en_reg, en_next;
  logic        pend_reg, pend_next;
  logic        tgl_prev_reg;
  logic        live_reg, live_next;
  logic [4:0]  idx_reg, idx_next;
  logic [16:0] tx_reg, tx_next;
  logic        ext_cnt_reg, ext_cnt_next;
  logic [31:0] entry_source_temp_reg, entry_source_temp_next;
  logic        halted_reg, halted_next;
  logic        resume_reg, resume_next;
  logic        exc_reg, exc_next;
  logic [7:0]  vec_reg, vec_next;
  logic        ack_reg, ack_next;
  logic        ill_reg, ill_next;
  logic        shalt_reg, shalt_next;
  logic        cipw_reg, cipw_next;
  logic [31:0] cipv_reg, cipv_next;
  logic        fout_reg, fout_next;
  logic        foe_reg, foe_next;
  logic        phi_reg, phi_next;
  logic        plo_reg, plo_next;

  logic        bit_tick;
  logic        ext_breakpoint_request_n;
  logic        dbl_fault;
  logic        is_debug_opc;
  logic        is_sw_breakpoint_request_n;
  logic [15:0] cmd_word;
  logic [4:0]  bit_pos;

  // Event decode
  // Ticks masked for one cycle after link release; clearing an odd
  // toggle at exit would otherwise echo as a received bit
  assign bit_tick     = (toggle_sync ^ tgl_prev_reg) & live_reg;
  assign ext_breakpoint_request_n     = core_event.breakpoint_request_n_ack &
                        ~(core_event.breakpoint_request_n_prefetch &
                          core_event.prefetch_flushed);
  assign dbl_fault    = core_event.bus_fault & pend_reg;
  assign is_debug_opc = core_event.opcode_valid &&
                        (opcode == `BDE_OPC_DEBUG);
  assign is_sw_breakpoint_request_n   = core_event.opcode_valid &&
                        (opcode >= `BDE_OPC_SWBKPT_LO) &&
                        (opcode <= `BDE_OPC_SWBKPT_HI);
  assign cmd_word     = rx_word[15:0]; // Status bit ignored

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    state_next             = state_reg;
    en_next                = en_reg;
    idx_next               = idx_reg;
    tx_next                = tx_reg;
    ext_cnt_next           = ext_cnt_reg;
    entry_source_temp_next = entry_source_temp_reg;
    vec_next               = vec_reg;
    cipv_next              = cipv_reg;
    shalt_next             = shalt_reg;
    resume_next            = 1'b0;
    exc_next               = 1'b0;
    ack_next               = 1'b0;
    ill_next               = 1'b0;
    cipw_next              = 1'b0;
    // Latch enable on the first cycle after reset release
    if (rst_d_reg) begin
      en_next = ~breakpoint_request_n_n_sync;
    end
    // Fault in progress; a new fault wins over completion
    pend_next = pend_reg;
    if (core_event.fault_done) begin
      pend_next = 1'b0;
    end
    if (core_event.bus_fault) begin
      pend_next = 1'b1;
    end
    case (state_reg)
      bde_pkg::ST_RUN: begin
        if (dbl_fault) begin
          if (en_reg) begin
            state_next             = bde_pkg::ST_WAIT;
            entry_source_temp_next = {fault_status_word,
                                      `BDE_SRC_DBL_LO};
            pend_next              = 1'b0;
            if (core_event.reset_fetch) begin
              cipw_next = 1'b1;
              cipv_next = `BDE_CIP_DBL_RESET;
            end
          end else begin
            shalt_next = 1'b1;
          end
        end else if (ext_breakpoint_request_n || core_event.periph_breakpoint_request_n) begin
          if (en_reg) begin
            state_next             = bde_pkg::ST_WAIT;
            entry_source_temp_next = {`BDE_SRC_ZERO,
                                      `BDE_SRC_ZERO};
          end else begin
            exc_next = 1'b1;
            vec_next = `BDE_VEC_BREAKPOINT_REQUEST_N;
            ack_next = ext_breakpoint_request_n;
          end
        end else if (is_debug_opc) begin
          if (en_reg) begin
            state_next             = bde_pkg::ST_WAIT;
            entry_source_temp_next = {`BDE_SRC_ZERO,
                                      `BDE_SRC_OPC_LO};
          end else begin
            ill_next = 1'b1;
          end
        end else if (is_sw_breakpoint_request_n) begin
          ill_next = 1'b1;
        end
        if (state_next == bde_pkg::ST_WAIT) begin
          idx_next = 5'h00;
          tx_next  = `BDE_RSP_NOT_READY;
        end
      end
      bde_pkg::ST_WAIT, bde_pkg::ST_EXT: begin
        if (bit_tick && idx_reg != `BDE_LAST_BIT) begin
          idx_next = idx_reg + 5'h01;
        end else if (bit_tick) begin
          idx_next = 5'h00;
          tx_next  = `BDE_RSP_NOT_READY;
          if (state_reg == bde_pkg::ST_EXT) begin
            // Extension words, high half first
            if (!ext_cnt_reg) begin
              entry_source_temp_next[31:16] = cmd_word;
              ext_cnt_next                  = 1'b1;
            end else begin
              entry_source_temp_next[15:0] = cmd_word;
              tx_next                      = `BDE_RSP_COMPLETE;
              state_next                   = bde_pkg::ST_WAIT;
            end
          end else if (cmd_word == `BDE_CMD_READ_SYSTEM_REG_CMD_HI) begin
            tx_next = {1'b0, entry_source_temp_reg[31:16]};
          end else if (cmd_word == `BDE_CMD_READ_SYSTEM_REG_CMD_LO) begin
            tx_next = {1'b0, entry_source_temp_reg[15:0]};
          end else if (cmd_word == `BDE_CMD_WSREG) begin
            state_next   = bde_pkg::ST_EXT;
            ext_cnt_next = 1'b0;
          end else if (cmd_word == `BDE_CMD_GO ||
                       cmd_word == `BDE_CMD_CALL) begin
            tx_next    = `BDE_RSP_COMPLETE;
            state_next = bde_pkg::ST_EXIT;
          end else begin
            tx_next = `BDE_RSP_ILLEGAL;
          end
        end
      end
      bde_pkg::ST_EXIT: begin
        state_next  = bde_pkg::ST_RUN;
        resume_next = 1'b1;
      end
      default: begin
        state_next = bde_pkg::ST_RUN;
      end
    endcase
    halted_next     = (state_next == bde_pkg::ST_WAIT) ||
                      (state_next == bde_pkg::ST_EXT);
    serial_off_next = ~halted_next;
    live_next       = ~serial_off_reg;
    // Serial output bit selected by received bit count
    bit_pos   = `BDE_LAST_BIT - idx_next;
    // Pins switch to serial use while halted
    fout_next = core_event.pipe_load | core_event.pipe_flush;
    foe_next  = ~halted_next;
    phi_next  = halted_next ? tx_next[bit_pos]
                            : core_event.pipe_advance;
    plo_next  = halted_next ? 1'b0 : core_event.instr_start;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg             <= bde_pkg::ST_RUN;
      rst_d_reg             <= 1'b1;
      en_reg                <= 1'b0;
      pend_reg              <= 1'b0;
      tgl_prev_reg          <= 1'b0;
      live_reg              <= 1'b0;
      idx_reg               <= 5'h00;
      tx_reg                <= `BDE_RSP_NOT_READY;
      ext_cnt_reg           <= 1'b0;
      entry_source_temp_reg <= 32'h00000000;
      halted_reg            <= 1'b0;
      serial_off_reg        <= 1'b1;
      resume_reg            <= 1'b0;
      exc_reg               <= 1'b0;
      vec_reg               <= 8'h00;
      ack_reg               <= 1'b0;
      ill_reg               <= 1'b0;
      shalt_reg             <= 1'b0;
      cipw_reg              <= 1'b0;
      cipv_reg              <= 32'h00000000;
      fout_reg              <= 1'b0;
      foe_reg               <= 1'b1;
      phi_reg               <= 1'b0;
      plo_reg               <= 1'b0;
    end else begin
      state_reg             <= state_next;
      rst_d_reg             <= 1'b0;
      en_reg                <= en_next;
      pend_reg              <= pend_next;
      tgl_prev_reg          <= toggle_sync;
      live_reg              <= live_next;
      idx_reg               <= idx_next;
      tx_reg                <= tx_next;
      ext_cnt_reg           <= ext_cnt_next;
      entry_source_temp_reg <= entry_source_temp_next;
      halted_reg            <= halted_next;
      serial_off_reg        <= serial_off_next;
      resume_reg            <= resume_next;
      exc_reg               <= exc_next;
      vec_reg               <= vec_next;
      ack_reg               <= ack_next;
      ill_reg               <= ill_next;
      shalt_reg             <= shalt_next;
      cipw_reg              <= cipw_next;
      cipv_reg              <= cipv_next;
      fout_reg              <= fout_next;
      foe_reg               <= foe_next;
      phi_reg               <= phi_next;
      plo_reg               <= plo_next;
    end
  end

  // Outputs straight from flops
  assign halted_out        = halted_reg;
  assign fetch_stop        = halted_reg;
  assign resume_prefetch   = resume_reg;
  assign debug_enabled     = en_reg;
  assign breakpoint_request_n_exception    = exc_reg;
  assign exception_vector  = vec_reg;
  assign breakpoint_request_n_ack_cycle    = ack_reg;
  assign illegal_trap      = ill_reg;
  assign system_halt       = shalt_reg;
  assign entry_source_temp = entry_source_temp_reg;
  assign cip_write         = cipw_reg;
  assign cip_value         = cipv_reg;
  assign fetch_track_out   = fout_reg;
  assign fetch_track_oe    = foe_reg;
  assign pipe_track_out_hi = phi_reg;
  assign pipe_track_out_lo = plo_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  en_latch_a: assert property (rst_d_reg |=>
    en_reg == !$past(breakpoint_request_n_n_sync))
    else $error("enable not latched at reset release");
  en_hold_a: assert property (!rst_d_reg |=> $stable(en_reg))
    else $error("enable changed outside reset");
  breakpoint_request_n_entry_a: assert property (
    state_reg == bde_pkg::ST_RUN && en_reg && ext_breakpoint_request_n && !dbl_fault
    |=> halted_out && fetch_stop && entry_source_temp == 32'h0)
    else $error("enabled breakpoint did not enter debug");
  breakpoint_request_n_exc_a: assert property (
    state_reg == bde_pkg::ST_RUN && !en_reg && !dbl_fault && ext_breakpoint_request_n
    |=> breakpoint_request_n_exception && exception_vector == 8'h0C && !halted_out)
    else $error("disabled breakpoint not an exception");
  dbl_halt_a: assert property (!en_reg && dbl_fault
    |=> system_halt [*2])
    else $error("double fault did not halt");
  opc_trap_a: assert property (
    state_reg == bde_pkg::ST_RUN && !en_reg && !dbl_fault &&
    !ext_breakpoint_request_n && !core_event.periph_breakpoint_request_n && is_debug_opc
    |=> illegal_trap && !halted_out)
    else $error("debug opcode not trapped");
  sw_breakpoint_request_n_a: assert property (
    state_reg == bde_pkg::ST_RUN && !dbl_fault && !ext_breakpoint_request_n &&
    !core_event.periph_breakpoint_request_n && is_sw_breakpoint_request_n
    |=> !halted_out && illegal_trap)
    else $error("software breakpoint entered debug");
  no_ack_a: assert property (
    state_reg == bde_pkg::ST_RUN && en_reg && ext_breakpoint_request_n
    |=> !breakpoint_request_n_ack_cycle)
    else $error("acknowledge cycle on debug entry");
  src_opc_a: assert property (
    state_reg == bde_pkg::ST_RUN && en_reg && is_debug_opc &&
    !dbl_fault && !ext_breakpoint_request_n && !core_event.periph_breakpoint_request_n
    |=> entry_source_temp == 32'h00000001)
    else $error("wrong entry source for debug opcode");
  cip_odd_a: assert property ($rose(cip_write) |->
    $past(dbl_fault) && $past(core_event.reset_fetch) && $past(en_reg))
    else $error("odd pointer written outside reset fault");
  exit_order_a: assert property ($fell(halted_out) |->
    !resume_prefetch ##1 resume_prefetch)
    else $error("prefetch resumed before halted dropped");
  halt_level_a: assert property (
    halted_out && !(bit_tick && idx_reg == `BDE_LAST_BIT) |=> halted_out)
    else $error("halted glitched during debug");

  cover property (state_reg == bde_pkg::ST_RUN && en_reg && ext_breakpoint_request_n);
  cover property (state_reg == bde_pkg::ST_RUN && en_reg && dbl_fault);
  cover property (halted_reg && bit_tick && idx_reg == `BDE_LAST_BIT);
  cover property (state_reg == bde_pkg::ST_EXIT);

endmodule : bde_top

`default_nettype wire

// ### bde_host.sv
// Serial debug master model: clocks 17-bit frames, MSB first.
// Assumes the device's data out is settled before each rising edge.
`timescale 1ns/1ps
`default_nettype none

module bde_host (
  output var  logic sclk,
  output var  logic sdata,
  input  wire logic debug_serial_out
);
  // ----------------------------------------------------------
  // Idle levels: clock parked high between frames
  // ----------------------------------------------------------
  initial begin
    sclk  = 1'b1;
    sdata = 1'b0;
  end

  // One frame: data moves on falling edge, latched on rising edge
  task automatic frame(input logic [16:0] tx, output logic [16:0] rx);
    #3;
    for (int i = 16; i >= 0; i--) begin
      sclk  = 1'b0;
      sdata = tx[i];
      #31;
      rx[i] = debug_serial_out;
      #1;
      sclk  = 1'b1;
      if (i > 0) begin
        #32;
      end
    end
    // Return just after the last edge so callers see the reply timing
    #2;
    sdata = ~sdata; // Released line shows no stale level
  endtask : frame
endmodule : bde_host
`default_nettype wire

// ### bde_top_tb_top.sv
// Self-checking testbench for the background debug entry block.
// Assumes bde_host as serial master and a 100 MHz core clock.
`timescale 1ns/1ps
`default_nettype none
`include "bde_params.svh"

module bde_top_tb_top;
  localparam logic [11:0] B_ACK = 12'h800;
  localparam logic [11:0] FLUSH = 12'hE00;
  localparam logic [11:0] PERIPH = 12'h100;
  localparam logic [11:0] FAULT = 12'h080;
  localparam logic [11:0] RFETCH = 12'h0A0;
  localparam logic [11:0] OPC = 12'h010;
  localparam logic [11:0] TRACK = 12'h00B;
  logic clk, sys_rst, breakpoint_request_n_n, sclk, sdata, ft_out, ft_oe, hi, lo;
  logic halted, fstop, resume, en, bexc, back, ill, shalt, cipw;
  logic [7:0] vec;
  logic [31:0] temp, cipv;
  logic [15:0] opc, fsw;
  bde_pkg::bde_event_type ev;
  int mismatches, compares;
  wire logic ft_in = ft_oe ? ft_out : sdata;

  bde_host host (.sclk(sclk), .sdata(sdata), .debug_serial_out(hi));
  bde_top dut (.clk(clk), .sys_rst(sys_rst), .breakpoint_request_n(breakpoint_request_n_n),
    .debug_serial_clock(sclk), .core_event(ev), .opcode(opc),
    .fault_status_word(fsw), .fetch_track_in(ft_in),
    .fetch_track_out(ft_out), .fetch_track_oe(ft_oe),
    .pipe_track_out_hi(hi), .pipe_track_out_lo(lo), .halted_out(halted),
    .fetch_stop(fstop), .resume_prefetch(resume), .debug_enabled(en),
    .breakpoint_request_n_exception(bexc), .exception_vector(vec), .breakpoint_request_n_ack_cycle(back),
    .illegal_trap(ill), .system_halt(shalt), .entry_source_temp(temp),
    .cip_write(cipw), .cip_value(cipv));

  // ----------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  // Reset with the pin strapped; enable latches on release
  task automatic do_reset(input logic strap);
    sys_rst = 1'b1;
    breakpoint_request_n_n  = strap;
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge clk);
    chk(en, !strap);
  endtask : do_reset

  // One event cycle; its result is visible on return
  task automatic ev_cycle(input logic [11:0] e, input logic [15:0] o);
    ev  = bde_pkg::bde_event_type'(e);
    opc = o;
    @(negedge clk);
  endtask : ev_cycle

  // One command frame, its reply is the previous command's result
  task automatic ser(input logic [15:0] cmd, input logic [16:0] exp);
    logic [16:0] r;
    host.frame({1'b0, cmd}, r);
    chk(r, exp);
    repeat (20) @(negedge clk);
    chk(halted, 1'b1);
  endtask : ser

  // Final frame then watch halted drop before the prefetch pulse
  task automatic leave(input logic [15:0] cmd, input logic [16:0] exp);
    logic [16:0] r;
    int n;
    host.frame({1'b0, cmd}, r);
    chk(r, exp);
    n = 0;
    @(negedge clk);
    while (halted !== 1'b0 && n < 50) begin
      chk(resume, 1'b0);
      @(negedge clk);
      n++;
    end
    chk({halted, ft_oe}, 2'b01);
    @(negedge clk);
    chk(resume, 1'b1);
  endtask : leave

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic t_disabled();
    do_reset(1'b1);
    ev_cycle(B_ACK, 16'h0000);
    chk({bexc, back, vec}, {2'b11, `BDE_VEC_BREAKPOINT_REQUEST_N});
    ev_cycle(OPC, `BDE_OPC_DEBUG);
    chk({ill, halted}, 2'b10);
    ev_cycle(OPC, `BDE_OPC_SWBKPT_LO);
    chk(halted, 1'b0);
    ev_cycle(TRACK, 16'h0000);
    chk({ft_out, hi, lo}, 3'b111);
    ev_cycle(FAULT, 16'h0000);
    ev_cycle(FAULT, 16'h0000);
    chk({shalt, halted}, 2'b10);
    ev_cycle(12'h000, 16'h0000);
    $display("test disabled done");
  endtask : t_disabled

  task automatic t_breakpoint_request_n();
    do_reset(1'b0);
    ev_cycle(FLUSH, 16'h0000);
    chk({halted, bexc}, 2'b00);
    ev_cycle(B_ACK, 16'h0000);
    chk({halted, fstop, ft_oe, back, bexc, cipw, hi}, 7'h61);
    chk(temp, 32'h00000000);
    ev_cycle(12'h000, 16'h0000);
    ser(16'h2D80, `BDE_RSP_NOT_READY);
    ser(16'h2D81, 17'h00000);
    ser(16'h1234, 17'h00000);
    leave(`BDE_CMD_GO, `BDE_RSP_ILLEGAL);
    $display("test breakpoint done");
  endtask : t_breakpoint_request_n

  task automatic t_opcode();
    ev_cycle(OPC, `BDE_OPC_SWBKPT_HI);
    chk(halted, 1'b0);
    ev_cycle(OPC, `BDE_OPC_DEBUG);
    chk({halted, ill}, 2'b10);
    chk(temp, 32'h00000001);
    ev_cycle(12'h000, 16'h0000);
    ser(16'h2D81, `BDE_RSP_NOT_READY);
    ser(`BDE_CMD_WSREG, 17'h00001);
    ser(16'h1357, `BDE_RSP_NOT_READY);
    ser(16'h2468, `BDE_RSP_NOT_READY);
    chk(temp, 32'h13572468);
    leave(`BDE_CMD_CALL, `BDE_RSP_COMPLETE);
    $display("test opcode done");
  endtask : t_opcode

  task automatic t_fault();
    do_reset(1'b0);
    ev_cycle(FAULT, 16'h0000);
    ev_cycle(RFETCH, 16'h0000);
    chk({halted, shalt, cipw}, 3'b101);
    chk(cipv, `BDE_CIP_DBL_RESET);
    chk(temp, {fsw, `BDE_SRC_DBL_LO});
    ev_cycle(12'h000, 16'h0000);
    leave(`BDE_CMD_GO, `BDE_RSP_NOT_READY);
    ev_cycle(PERIPH, 16'h0000);
    chk(halted, 1'b1);
    chk(temp, 32'h00000000);
    ev_cycle(12'h000, 16'h0000);
    leave(`BDE_CMD_GO, `BDE_RSP_NOT_READY);
    $display("test fault done");
  endtask : t_fault

  // ----------------------------------------------------------
  // Clock, main sequence and watchdog
  // ----------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    sys_rst = 1'b1;
    breakpoint_request_n_n = 1'b1;
    ev = '0;
    opc = 16'h0000;
    fsw = 16'hABCD;
    mismatches = 0;
    compares = 0;
    @(negedge clk);
    t_disabled();
    t_breakpoint_request_n();
    t_opcode();
    t_fault();
    conclude();
  end

  initial begin
    #200000;
    mismatches++;
    conclude();
  end
endmodule : bde_top_tb_top
`default_nettype wire
